/* core/fbh_pkg.sv */
// Purpose: Shared constants and types of the flash erase select and boot hand-off block
// Assumes: 32-bit AHB-Lite data, one aligned word per register
// Notes: Register offsets are byte addresses on the bus
package fbh_pkg;
  // Register byte offsets
  localparam logic [7:0] FBH_OFS_FC1 = 8'h00;
  localparam logic [7:0] FBH_OFS_FC2 = 8'h04;
  localparam logic [7:0] FBH_OFS_EBS = 8'h08;
  localparam logic [7:0] FBH_OFS_ACC = 8'h0C;
  localparam logic [7:0] FBH_OFS_BSTAT = 8'h10;
  // Field positions
  localparam int FBH_WEN_BIT = 6;
  localparam int FBH_ACC_BIT = 7;
  localparam int FBH_EB_W = 5;
  // Reset values
  localparam logic [7:0] FBH_RST_BYTE = 8'h00;
  localparam logic [31:0] FBH_RST_WORD = 32'h0000_0000;
  // Boot handshake bytes
  localparam logic [7:0] FBH_ADJ_END = 8'h00;
  localparam logic [7:0] FBH_SYNC_BYTE = 8'h55;
  // Download area in on-chip RAM
  localparam logic [15:0] FBH_RAM_FIRST = 16'hF780;
  localparam logic [15:0] FBH_RAM_LAST = 16'hFEEF;
  // Erase regions, one per select bit
  localparam logic [15:0] FBH_BLK0_LO = 16'h0000;
  localparam logic [15:0] FBH_BLK0_HI = 16'h03FF;
  localparam logic [15:0] FBH_BLK1_LO = 16'h0400;
  localparam logic [15:0] FBH_BLK1_HI = 16'h07FF;
  localparam logic [15:0] FBH_BLK2_LO = 16'h0800;
  localparam logic [15:0] FBH_BLK2_HI = 16'h0BFF;
  localparam logic [15:0] FBH_BLK3_LO = 16'h0C00;
  localparam logic [15:0] FBH_BLK3_HI = 16'h0FFF;
  localparam logic [15:0] FBH_BLK4_LO = 16'h1000;
  localparam logic [15:0] FBH_BLK4_HI = 16'h7FFF;
  localparam logic [15:0] FBH_NO_ADDR = 16'h0000;

  typedef enum logic [2:0] {
    FBH_B_STRAP = 3'b000,
    FBH_B_OFF = 3'b001,
    FBH_B_ADJ = 3'b010,
    FBH_B_ACK = 3'b011,
    FBH_B_SYNC = 3'b100,
    FBH_B_LOAD = 3'b101,
    FBH_B_HAND = 3'b110,
    FBH_B_RUN = 3'b111
  } fbh_boot_t;
endpackage

/* core/fbh_ahb_port.sv */
// Purpose: AHB-Lite slave front end, turns bus phases into register strobes
// Assumes: Single word transfers, one slave on the bus
// Notes: Writes finish with no wait state, reads take one wait state
`timescale 1ns/1ps
module fbh_ahb_port
  import fbh_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Bus address phase
  input wire logic hsel_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [7:0] haddr_in,
  input wire logic hready_in,
  // Strobes to the register file
  output logic wr_stb_out,
  output logic rd_stb_out,
  output logic [7:0] addr_out,
  output logic hreadyout_out
);
  typedef struct packed {
    logic vld;
    logic wr;
    logic [7:0] addr;
    logic rd_done;
  } fbh_ahb_st_t;

  fbh_ahb_st_t q_r;
  fbh_ahb_st_t q_nxt;

  always_comb begin
    q_nxt = q_r;
    if (hreadyout_out) begin
      q_nxt.vld = hsel_in && htrans_in[1] && hready_in;
      q_nxt.wr = hwrite_in;
      q_nxt.addr = haddr_in;
      q_nxt.rd_done = 1'b0;
    end else begin
      // Read data is registered, so the first data cycle stalls
      q_nxt.rd_done = 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign wr_stb_out = q_r.vld && q_r.wr;
  assign rd_stb_out = q_r.vld && !q_r.wr && !q_r.rd_done;
  assign addr_out = q_r.addr;
  assign hreadyout_out = !rd_stb_out;
endmodule

/* core/fbh_erase_sel.sv */
// Purpose: Erase block select register with one-hot guard and region decode
// Assumes: Write strobe already gated by the access enable
// Notes: Region outputs follow the select bits on the same edge
`timescale 1ns/1ps
module fbh_erase_sel
  import fbh_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Control
  input wire logic wen_in,
  input wire logic wr_in,
  input wire logic [7:0] wdata_in,
  // Selected region
  output logic [FBH_EB_W-1:0] sel_out,
  output logic [15:0] lo_out,
  output logic [15:0] hi_out
);
  typedef struct packed {
    logic [FBH_EB_W-1:0] sel;
    logic [15:0] lo;
    logic [15:0] hi;
  } fbh_ebs_st_t;

  fbh_ebs_st_t q_r;
  fbh_ebs_st_t q_nxt;

  always_comb begin
    q_nxt = q_r;
    if (!wen_in) begin
      q_nxt.sel = '0;
    end else if (wr_in) begin
      // Two or more bits would erase an unintended area
      q_nxt.sel = ($countones(wdata_in[FBH_EB_W-1:0]) > 1) ? '0 : wdata_in[FBH_EB_W-1:0];
    end
    case (q_nxt.sel)
      5'b10000: begin
        q_nxt.lo = FBH_BLK4_LO;
        q_nxt.hi = FBH_BLK4_HI;
      end
      5'b01000: begin
        q_nxt.lo = FBH_BLK3_LO;
        q_nxt.hi = FBH_BLK3_HI;
      end
      5'b00100: begin
        q_nxt.lo = FBH_BLK2_LO;
        q_nxt.hi = FBH_BLK2_HI;
      end
      5'b00010: begin
        q_nxt.lo = FBH_BLK1_LO;
        q_nxt.hi = FBH_BLK1_HI;
      end
      5'b00001: begin
        q_nxt.lo = FBH_BLK0_LO;
        q_nxt.hi = FBH_BLK0_HI;
      end
      default: begin
        q_nxt.lo = FBH_NO_ADDR;
        q_nxt.hi = FBH_NO_ADDR;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign sel_out = q_r.sel;
  assign lo_out = q_r.lo;
  assign hi_out = q_r.hi;
endmodule

/* core/fbh_flash_boot.sv */
// Purpose: Flash control registers, erase select and boot-mode serial hand-off
// Assumes: Serial bytes arrive already framed; bit-rate match is reported by lock pulse
// Notes: Boot strap is sampled once, on the first clock after reset release
//
// The implementer's own choices: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
module fbh_flash_boot
  import fbh_pkg::*;
(
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // AHB-Lite slave
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  // Boot control
  input wire logic boot_mode_in,
  input wire logic wdt_overflow_in,
  input wire logic baud_lock_in,
  input wire logic [7:0] baud_value_in,
  // Boot serial port bytes
  input wire logic rx_valid_in,
  input wire logic [7:0] rx_data_in,
  input wire logic tx_ready_in,
  output logic tx_valid_out,
  output logic [7:0] tx_data_out,
  output logic serial_receive_enable_out,
  output logic serial_transmit_enable_out,
  output logic [7:0] baud_rate_register_out,
  output logic port_direction_bit_out,
  output logic port_data_bit_out,
  // RAM download
  output logic ram_we_out,
  output logic [15:0] ram_addr_out,
  output logic [7:0] ram_wdata_out,
  // Status
  output logic boot_active_out,
  output logic boot_ram_lock_out,
  output logic jump_out,
  // Flash control
  output logic [7:0] flash_control_one_out,
  output logic [7:0] flash_control_two_out,
  output logic [FBH_EB_W-1:0] erase_block_select_out,
  output logic [15:0] erase_lo_out,
  output logic [15:0] erase_hi_out
);
  typedef struct packed {
    logic [7:0] fc1;
    logic [7:0] fc2;
    logic access_en;
    logic [31:0] hrdata;
    fbh_boot_t st;
    logic [7:0] baud;
    logic rx_en;
    logic tx_en;
    logic dir;
    logic dat;
    logic [7:0] tx_data;
    logic [15:0] ptr;
    logic ram_we;
    logic [15:0] ram_addr;
    logic [7:0] ram_wdata;
    logic jump;
  } fbh_top_st_t;

  fbh_top_st_t q_r;
  fbh_top_st_t q_nxt;
  logic [1:0] rst_sync_r;
  logic rst_n;
  logic wr_stb;
  logic rd_stb;
  logic [7:0] addr;
  logic gated;
  logic ebs_wr;
  logic [31:0] rdata;

  // Async assert, clocked release
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_sync_r <= 2'b00;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  fbh_ahb_port u_ahb (
    .clk_in(mclk_in),
    .rst_n_in(rst_n),
    .hsel_in(hsel_in),
    .htrans_in(htrans_in),
    .hwrite_in(hwrite_in),
    .haddr_in(haddr_in[7:0]),
    .hready_in(hready_in),
    .wr_stb_out(wr_stb),
    .rd_stb_out(rd_stb),
    .addr_out(addr),
    .hreadyout_out(hreadyout_out)
  );

  // Flash control registers stay invisible until the access bit is set
  assign gated = (addr == FBH_OFS_FC1) || (addr == FBH_OFS_FC2) || (addr == FBH_OFS_EBS);
  assign ebs_wr = wr_stb && (addr == FBH_OFS_EBS) && q_r.access_en;

  fbh_erase_sel u_ebs (
    .clk_in(mclk_in),
    .rst_n_in(rst_n),
    .wen_in(q_r.fc1[FBH_WEN_BIT]),
    .wr_in(ebs_wr),
    .wdata_in(hwdata_in[7:0]),
    .sel_out(erase_block_select_out),
    .lo_out(erase_lo_out),
    .hi_out(erase_hi_out)
  );

  always_comb begin
    rdata = FBH_RST_WORD;
    if (gated && !q_r.access_en) begin
      rdata = FBH_RST_WORD;
    end else begin
      case (addr)
        FBH_OFS_FC1: rdata = {24'h00_0000, q_r.fc1};
        FBH_OFS_FC2: rdata = {24'h00_0000, q_r.fc2};
        FBH_OFS_EBS: rdata = {27'h000_0000, erase_block_select_out};
        FBH_OFS_ACC: rdata = {24'h00_0000, q_r.access_en, 7'h00};
        FBH_OFS_BSTAT: rdata = {16'h0000, q_r.baud, q_r.dat, q_r.dir, q_r.tx_en, q_r.rx_en, 1'b0, q_r.st};
        default: rdata = FBH_RST_WORD;
      endcase
    end
  end

  always_comb begin
    q_nxt = q_r;
    q_nxt.ram_we = 1'b0;
    q_nxt.jump = 1'b0;
    if (rd_stb) begin
      q_nxt.hrdata = rdata;
    end
    if (wr_stb) begin
      if (addr == FBH_OFS_ACC) begin
        q_nxt.access_en = hwdata_in[FBH_ACC_BIT];
      end
      if (q_r.access_en && addr == FBH_OFS_FC1) begin
        q_nxt.fc1 = hwdata_in[7:0];
      end
      if (q_r.access_en && addr == FBH_OFS_FC2) begin
        q_nxt.fc2 = hwdata_in[7:0];
      end
    end
    // Strap is read once; later changes on boot_mode_in are ignored
    case (q_r.st)
      FBH_B_STRAP: begin
        q_nxt.st = boot_mode_in ? FBH_B_ADJ : FBH_B_OFF;
        q_nxt.rx_en = boot_mode_in;
        q_nxt.tx_en = boot_mode_in;
      end
      FBH_B_ADJ: begin
        if (baud_lock_in) begin
          q_nxt.baud = baud_value_in;
          q_nxt.tx_data = FBH_ADJ_END;
          q_nxt.st = FBH_B_ACK;
        end
      end
      FBH_B_ACK: begin
        if (tx_ready_in) begin
          q_nxt.st = FBH_B_SYNC;
        end
      end
      FBH_B_SYNC: begin
        // Other bytes are ignored; a failed host recovers by reset
        if (rx_valid_in && rx_data_in == FBH_SYNC_BYTE) begin
          q_nxt.ptr = FBH_RAM_FIRST;
          q_nxt.st = FBH_B_LOAD;
        end
      end
      FBH_B_LOAD: begin
        if (rx_valid_in) begin
          q_nxt.ram_we = 1'b1;
          q_nxt.ram_addr = q_r.ptr;
          q_nxt.ram_wdata = rx_data_in;
          q_nxt.ptr = q_r.ptr + 16'h0001;
          if (q_r.ptr == FBH_RAM_LAST) begin
            q_nxt.st = FBH_B_HAND;
          end
        end
      end
      FBH_B_HAND: begin
        q_nxt.rx_en = 1'b0;
        q_nxt.tx_en = 1'b0;
        q_nxt.dir = 1'b1;
        q_nxt.dat = 1'b1;
        q_nxt.jump = 1'b1;
        q_nxt.st = FBH_B_RUN;
      end
      FBH_B_RUN: begin
        q_nxt.st = FBH_B_RUN;
      end
      FBH_B_OFF: begin
        q_nxt.st = FBH_B_OFF;
      end
      default: begin
        q_nxt.st = FBH_B_OFF;
      end
    endcase
    if (wdt_overflow_in && q_r.st != FBH_B_STRAP) begin
      q_nxt.st = FBH_B_OFF;
      q_nxt.rx_en = 1'b0;
      q_nxt.tx_en = 1'b0;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign hrdata_out = q_r.hrdata;
  assign hresp_out = 1'b0;
  assign tx_valid_out = (q_r.st == FBH_B_ACK);
  assign tx_data_out = q_r.tx_data;
  assign serial_receive_enable_out = q_r.rx_en;
  assign serial_transmit_enable_out = q_r.tx_en;
  assign baud_rate_register_out = q_r.baud;
  assign port_direction_bit_out = q_r.dir;
  assign port_data_bit_out = q_r.dat;
  assign ram_we_out = q_r.ram_we;
  assign ram_addr_out = q_r.ram_addr;
  assign ram_wdata_out = q_r.ram_wdata;
  // Boot work area stays reserved while the loader runs
  assign boot_ram_lock_out = (q_r.st >= FBH_B_ADJ) && (q_r.st <= FBH_B_HAND);
  assign boot_active_out = (q_r.st != FBH_B_OFF) && (q_r.st != FBH_B_STRAP);
  assign jump_out = q_r.jump;
  assign flash_control_one_out = q_r.fc1;
  assign flash_control_two_out = q_r.fc2;

  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rst_n);

  a_ebs_wen_clear: assert property (!q_r.fc1[FBH_WEN_BIT] |=> erase_block_select_out == 5'b00000)
    else $error("erase select not cleared without write enable");
  a_ebs_multi_clear: assert property (ebs_wr && q_r.fc1[FBH_WEN_BIT] && $countones(hwdata_in[4:0]) > 1
    |=> erase_block_select_out == 5'b00000)
    else $error("multi-bit erase select not cleared");
  a_large_region: assert property (erase_block_select_out == 5'b10000
    |-> erase_lo_out == 16'h1000 && erase_hi_out == 16'h7FFF)
    else $error("large block region wrong");
  a_small_region: assert property (erase_block_select_out == 5'b01000
    |-> erase_lo_out == 16'h0C00 && erase_hi_out == 16'h0FFF)
    else $error("block three region wrong");
  a_reserved_zero: assert property (rd_stb && addr == FBH_OFS_ACC |=> hrdata_out[6:0] == 7'h00)
    else $error("reserved bits read nonzero");
  a_gate_write: assert property (wr_stb && addr == FBH_OFS_FC1 && !q_r.access_en |=> $stable(q_r.fc1))
    else $error("gated write took effect");
  a_gate_read: assert property (rd_stb && gated && !q_r.access_en |=> hrdata_out == 32'h0000_0000)
    else $error("gated read not zero");
  a_ack_once: assert property (tx_valid_out && tx_ready_in |=> !tx_valid_out [*2])
    else $error("adjustment byte sent twice");
  a_ram_window: assert property (ram_we_out |-> ram_addr_out >= 16'hF780 && ram_addr_out <= 16'hFEEF)
    else $error("download outside RAM window");
  a_ram_release: assert property ($rose(jump_out) |-> !boot_ram_lock_out && $past(boot_ram_lock_out))
    else $error("boot RAM lock wrong at hand-off");
  a_handoff_serial: assert property (jump_out |-> !serial_receive_enable_out && !serial_transmit_enable_out
    && $stable(baud_rate_register_out))
    else $error("serial not stopped at hand-off");
  a_handoff_pin: assert property (jump_out |-> port_direction_bit_out && port_data_bit_out)
    else $error("transmit pin not high at hand-off");
  a_wdt_exit: assert property (wdt_overflow_in && q_r.st != FBH_B_STRAP |=> !boot_active_out)
    else $error("watchdog did not end boot mode");
  a_gate_fc2: assert property (wr_stb && addr == FBH_OFS_FC2 && !q_r.access_en |=> $stable(q_r.fc2))
    else $error("gated second control write took effect");
  a_block0_region: assert property (erase_block_select_out == 5'b00001
    |-> erase_lo_out == 16'h0000 && erase_hi_out == 16'h03FF)
    else $error("block zero region wrong");
  a_wdt_serial: assert property (wdt_overflow_in && q_r.st != FBH_B_STRAP
    |=> !serial_receive_enable_out && !serial_transmit_enable_out)
    else $error("watchdog left serial enabled");
endmodule

/* verification/fbh_host_model.sv */
// Purpose: Host computer on the far side of the boot serial handshake
// Assumes: Byte-level link, one byte per rx_valid cycle
// Notes: Slow mode delays the acknowledge and leaves a gap after every byte
`timescale 1ns/1ps
module fbh_host_model #(
  parameter logic [7:0] BAUD = 8'h1A,
  parameter int NBYTES = 1904
) (
  // Clock, reset and pacing
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic slow_in,
  // Device side
  input wire logic tx_valid_in,
  output logic baud_lock_out,
  output logic [7:0] baud_value_out,
  output logic tx_ready_out,
  output logic rx_valid_out,
  output logic [7:0] rx_data_out
);
  int k;
  task automatic send(input logic [7:0] b);
    rx_valid_out <= 1'b1;
    rx_data_out <= b;
    @(posedge clk_in);
    if (slow_in) begin
      rx_valid_out <= 1'b0;
      rx_data_out <= ~b;
      @(posedge clk_in);
    end
  endtask
  initial begin
    baud_lock_out = 1'b0;
    baud_value_out = ~BAUD;
    tx_ready_out = 1'b0;
    rx_valid_out = 1'b0;
    rx_data_out = 8'h00;
    forever begin
      @(posedge rst_n_in);
      repeat (6) @(posedge clk_in);
      baud_lock_out <= 1'b1;
      baud_value_out <= BAUD;
      @(posedge clk_in);
      baud_lock_out <= 1'b0;
      baud_value_out <= ~BAUD;
      do @(posedge clk_in); while (tx_valid_in !== 1'b1);
      if (slow_in) @(posedge clk_in);
      tx_ready_out <= 1'b1;
      @(posedge clk_in);
      tx_ready_out <= 1'b0;
      @(posedge clk_in);
      send(8'h55);
      // Image sets up its own stack first
      for (k = 0; k < NBYTES; k++) send(8'(k * 37));
      rx_valid_out <= 1'b0;
      rx_data_out <= ~rx_data_out;
    end
  end
endmodule

/* verification/flash_erase_select_and_boot_handoff_bench.sv */
// Purpose: Self-checking bench for the flash erase select and boot hand-off block
// Assumes: Bus master waits on hready, host model runs the boot link
// Notes: Register model kept in integers, compared at every read
`timescale 1ns/1ps
module flash_erase_select_and_boot_handoff_bench
  import fbh_pkg::*;
;
  localparam logic [7:0] BAUD = 8'h1A;
  logic mclk_in, rst_n_in, hsel, hwrite, boot, wdt, slow, hready, hresp, lock, txr, rxv;
  logic txv, rxe, txe, dir, dat, we, act, rlock, jmp;
  logic [1:0] htrans;
  logic [7:0] haddr, bval, rxd, txd, brate, wd, rnd, fc1o, fc2o;
  logic [31:0] hwdata, hrdata, hrd, lfsr_v;
  logic [15:0] radr, elo, ehi;
  logic [4:0] ebs;
  int n_fail, checks, cyc, nw, njmp, ntx, i, m_fc1, m_fc2, m_ebs, m_acc;

  fbh_flash_boot dut (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .hsel_in(hsel), .haddr_in({24'h00_0000, haddr}),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'b010), .hwdata_in(hwdata), .hready_in(hready),
    .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp), .boot_mode_in(boot),
    .wdt_overflow_in(wdt), .baud_lock_in(lock), .baud_value_in(bval), .rx_valid_in(rxv), .rx_data_in(rxd),
    .tx_ready_in(txr), .tx_valid_out(txv), .tx_data_out(txd), .serial_receive_enable_out(rxe),
    .serial_transmit_enable_out(txe), .baud_rate_register_out(brate), .port_direction_bit_out(dir),
    .port_data_bit_out(dat), .ram_we_out(we), .ram_addr_out(radr), .ram_wdata_out(wd),
    .boot_active_out(act), .boot_ram_lock_out(rlock), .jump_out(jmp), .flash_control_one_out(fc1o),
    .flash_control_two_out(fc2o), .erase_block_select_out(ebs), .erase_lo_out(elo), .erase_hi_out(ehi));

  fbh_host_model #(.BAUD(BAUD), .NBYTES(1904)) host (.clk_in(mclk_in), .rst_n_in(rst_n_in), .slow_in(slow),
    .tx_valid_in(txv), .baud_lock_out(lock), .baud_value_out(bval), .tx_ready_out(txr),
    .rx_valid_out(rxv), .rx_data_out(rxd));

  task automatic print_verdict();
    if (n_fail == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  function automatic logic [31:0] region(input int s);
    case (s)
      1: return 32'h0000_03FF;
      2: return 32'h0400_07FF;
      4: return 32'h0800_0BFF;
      8: return 32'h0C00_0FFF;
      16: return 32'h1000_7FFF;
      default: return 32'h0000_0000;
    endcase
  endfunction

  // Address phase held until hready, data phase likewise
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= a;
    do @(posedge mclk_in); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge mclk_in); while (hready !== 1'b1);
    hrd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input int d);
    xfer(1'b1, a, 32'(d));
    if (a == FBH_OFS_ACC) m_acc = d & 'h80;
    if (m_acc != 0 && a == FBH_OFS_FC1) m_fc1 = d & 'hFF;
    if (m_acc != 0 && a == FBH_OFS_FC2) m_fc2 = d & 'hFF;
    if (m_acc != 0 && a == FBH_OFS_EBS && m_fc1[6]) m_ebs = ($countones(d[4:0]) == 1) ? d & 'h1F : 0;
    if (!m_fc1[6]) m_ebs = 0;
  endtask

  task automatic rd(input logic [7:0] a);
    int e;
    e = (a == FBH_OFS_ACC) ? m_acc : 0;
    if (m_acc != 0 && a == FBH_OFS_FC1) e = m_fc1;
    if (m_acc != 0 && a == FBH_OFS_FC2) e = m_fc2;
    if (m_acc != 0 && a == FBH_OFS_EBS) e = m_ebs;
    xfer(1'b0, a, 32'h0000_0000);
    chk(hrd, e);
    chk(hresp, 1'b0);
    chk({fc1o, fc2o}, {m_fc1[7:0], m_fc2[7:0]});
    chk(ebs, m_ebs);
    chk({elo, ehi}, region(m_ebs));
  endtask

  initial begin
    mclk_in = 1'b0;
    forever #12.5 mclk_in = ~mclk_in;
  end

  // Boot link monitor and hang guard
  always @(posedge mclk_in) begin
    cyc++;
    if (txv === 1'b1 && txr === 1'b1) begin
      ntx++;
      chk(txd, 8'h00);
    end
    if (we === 1'b1) begin
      chk({rlock, radr, wd}, {1'b1, 16'hF780 + 16'(nw), 8'(nw * 37)});
      nw++;
    end
    if (jmp === 1'b1) njmp++;
    // Two boots and the register tests need under 3000 cycles
    if (cyc == 6000) begin
      n_fail++;
      print_verdict();
    end
  end

  initial begin
    {rst_n_in, htrans, hwrite, haddr, hwdata, wdt, slow} = '0;
    {n_fail, checks, cyc, nw, njmp, ntx, m_fc1, m_fc2, m_ebs, m_acc} = '0;
    hsel = 1'b1;
    boot = 1'b1;
    lfsr_v = 32'h9666;
    repeat (12) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    repeat (5) @(posedge mclk_in);
    for (i = 0; i < 6; i++) if (i != 4) rd(8'(i * 4));
    // Refused while the access bit is clear
    wr(FBH_OFS_FC1, 'h40);
    wr(FBH_OFS_FC2, 'hFF);
    wr(8'h14, 'hFF);
    wr(FBH_OFS_ACC, 'hFF);
    for (i = 0; i < 6; i++) if (i != 4) rd(8'(i * 4));
    wr(FBH_OFS_EBS, 'h01);
    rd(FBH_OFS_EBS);
    wr(FBH_OFS_FC1, 'h40);
    for (i = 0; i < 5; i++) begin
      wr(FBH_OFS_EBS, 1 << i);
      rd(FBH_OFS_EBS);
    end
    // Biased toward one-hot so both outcomes show up
    for (i = 0; i < 40; i++) begin
      lfsr_v = lfsr(lfsr_v);
      rnd = lfsr_v[3] ? {lfsr_v[7:5], 5'(1 << (lfsr_v[2:0] % 5))} : lfsr_v[7:0];
      wr(FBH_OFS_EBS, rnd);
      rd(FBH_OFS_EBS);
    end
    wr(FBH_OFS_EBS, 'h04);
    wr(FBH_OFS_FC1, 'h00);
    rd(FBH_OFS_EBS);
    wr(FBH_OFS_ACC, 'h00);
    wr(FBH_OFS_FC1, 'h40);
    rd(FBH_OFS_FC1);
    wr(FBH_OFS_ACC, 'h80);
    rd(FBH_OFS_FC1);
    wr(FBH_OFS_FC2, 'hA5);
    rd(FBH_OFS_FC2);
    i = 0;
    while (njmp == 0 && i < 4000) begin
      @(posedge mclk_in);
      i++;
    end
    @(posedge mclk_in);
    chk(ntx, 1);
    chk(nw, 1904);
    chk({act, rlock, rxe, txe, brate, dir, dat}, {4'b1000, BAUD, 2'b11});
    xfer(1'b0, FBH_OFS_BSTAT, 32'h0000_0000);
    chk(hrd[15:0], {BAUD, 8'hC7});
    // Reset, then a second boot in slow mode, ended by watchdog in mid-download
    rst_n_in <= 1'b0;
    repeat (20) @(posedge mclk_in);
    chk({act, rlock, jmp}, 0);
    nw = 0;
    slow <= 1'b1;
    rst_n_in <= 1'b1;
    i = 0;
    while (nw < 100 && i < 2000) begin
      @(posedge mclk_in);
      i++;
    end
    chk(32'(nw >= 100), 1);
    wdt <= 1'b1;
    @(posedge mclk_in);
    wdt <= 1'b0;
    repeat (3) @(posedge mclk_in);
    chk({act, rxe, txe, brate}, {3'b000, BAUD});
    i = nw;
    repeat (40) @(posedge mclk_in);
    chk(nw, i);
    chk(njmp, 1);
    print_verdict();
  end
endmodule
